// ===== logic/onchip_mem_map.sv
// on-chip program, x and y memories with their address decode,
// boot window, reserved-space answers and interrupt vector lookup
// assumes the core drives one request per space per cycle, reads
// return one cycle later, and software reaches config over apb
//
// config at 0x00 resets with boot active
// status at 0x04 counts illegal reads, wraps
// size at 0x08 shows the current program and y ram sizes; x only as a zero flag
// arrays have no reset, like real ram
// no interrupt logic; illegal pulse goes out
// x and y reserved reads pulse it as well
//
// How it works
// - program memory is 24 bits, addressed by core
// - move-to-program writes update program ram
// - vectors live in lowest 128 program words
// - fixed level-3 vectors at documented slots
// - audio port vectors, relocation bits clear
// - relocation moves audio vectors to 0x40-0x4A
// - serial host port vectors at documented slots
// - parallel host vectors and host command slots
// - audio transmitter vectors at documented slots
// - x and y memories 24 bits, own buses
// - split bits pick program ram size
// - split bits pick x and y ram size
// - rom sizes fixed in every layout
// - no external memory; everything decodes on chip
// - boot rom answers program words 0 to 31
// - loader source chosen by boot select bits
// - boot mode blocks reads of words 32 to 255
// - writes to reserved space are dropped
// - illegal reserved reads return 0x000005, interrupt
// - reserved data below 0x2000 reads undefined
// - fetch from reserved space gives illegal opcode
`timescale 1ns/1ps
`default_nettype none

module onchip_mem_map #(
  parameter logic [23:0] BOOT_ROM_WORD = 24'h000000
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire onchip_mem_pkg::mem_req_t i_p_req,
  input wire onchip_mem_pkg::mem_req_t i_x_req,
  input wire onchip_mem_pkg::mem_req_t i_y_req,
  output logic [23:0] o_p_rdata,
  output logic [23:0] o_x_rdata,
  output logic [23:0] o_y_rdata,
  output logic o_illegal_irq,
  input wire onchip_mem_pkg::vec_req_t i_vec_req,
  output onchip_mem_pkg::vec_out_t o_vec,
  output logic [2:0] o_boot_sel,
  output logic o_boot_active
);

  typedef enum logic [2:0] {
    K_RAM, K_ROM, K_BOOT, K_BLOCK, K_ILL, K_UNDEF
  } kind_t;

  typedef struct packed {
    logic [7:0] cfg;
    logic [15:0] ill_cnt;
    logic ill_irq;
    onchip_mem_pkg::vec_out_t vec;
    logic [31:0] prdata;
    logic slverr;
  } state_t;

  // all control state in one struct
  state_t st_r;
  state_t st_nxt;

  // ram words of the chosen layout
  logic [12:0] pram_w;
  logic [12:0] xram_w;
  logic [12:0] yram_w;

  // kind of each access; picks enable and mux
  kind_t p_kind;
  kind_t d_kind [2];
  logic [23:0] d_rdata [2];

  // sized for the largest layout; smaller
  // layouts leave top words unreachable
  localparam int unsigned PRAM_DEPTH = onchip_mem_pkg::PRAM_DEPTH;
  logic [23:0] pram [PRAM_DEPTH];

  // split bits and apb write strobe
  logic [1:0] split;
  logic apb_wr;

  // a new layout applies from the access
  // after the apb write lands
  assign split = {st_r.cfg[onchip_mem_pkg::CFG_SPLIT_B],
                  st_r.cfg[onchip_mem_pkg::CFG_SPLIT_A]};

  // ram sizes per layout; roms keep one fixed window each
  // x and y give up what program ram gains
  always_comb begin
    case (split)
      2'b00: begin
        pram_w = onchip_mem_pkg::PRAM_W0;
        xram_w = onchip_mem_pkg::XRAM_W0;
        yram_w = onchip_mem_pkg::YRAM_W0;
      end
      2'b01: begin
        pram_w = onchip_mem_pkg::PRAM_W1;
        xram_w = onchip_mem_pkg::XRAM_W1;
        yram_w = onchip_mem_pkg::YRAM_W0;
      end
      2'b10: begin
        pram_w = onchip_mem_pkg::PRAM_W2;
        xram_w = onchip_mem_pkg::XRAM_W1;
        yram_w = onchip_mem_pkg::YRAM_W2;
      end
      default: begin
        pram_w = onchip_mem_pkg::PRAM_W3;
        xram_w = onchip_mem_pkg::XRAM_W3;
        yram_w = onchip_mem_pkg::YRAM_W2;
      end
    endcase
  end

  // program space decode; no external window exists at all
  // boot rom wins over ram in the low words;
  // words up to 0xFF stay read-blocked so a
  // half-loaded program is never fetched
  // the gap below program rom is reserved
  always_comb begin
    if (o_boot_active &&
        i_p_req.addr <= onchip_mem_pkg::BOOT_ROM_END) begin
      p_kind = K_BOOT;
    end else if (i_p_req.addr < {3'h0, pram_w}) begin
      if (o_boot_active &&
          i_p_req.addr <= onchip_mem_pkg::BOOT_PROT_END) begin
        p_kind = K_BLOCK;
      end else begin
        p_kind = K_RAM;
      end
    end else if (i_p_req.addr >= onchip_mem_pkg::PROM_BASE &&
                 i_p_req.addr <= onchip_mem_pkg::PROM_LAST) begin
      p_kind = K_ROM;
    end else begin
      p_kind = K_ILL;
    end
  end

  // program ram: writes by the program-move path, also during boot
  // decode has already refused other words
  always_ff @(posedge i_mclk) begin
    if (i_p_req.req && i_p_req.we &&
        (p_kind == K_RAM || p_kind == K_BLOCK)) begin
      pram[i_p_req.addr[11:0]] <= i_p_req.wdata;
    end
  end

  // program read data, one cycle after the request
  // holds while no read comes; writes keep it
  // rom contents live outside: fixed fill
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_p_rdata <= 24'h000000;
    end else if (i_p_req.req && !i_p_req.we) begin
      case (p_kind)
        K_RAM: o_p_rdata <= pram[i_p_req.addr[11:0]];
        K_BOOT: o_p_rdata <= BOOT_ROM_WORD;
        K_ROM: o_p_rdata <= onchip_mem_pkg::ROM_FILL;
        K_BLOCK: o_p_rdata <= onchip_mem_pkg::BLOCK_FILL;
        default: o_p_rdata <= onchip_mem_pkg::ILLEGAL_OP;
      endcase
    end
  end

  // x and y spaces share one structure with their own limits
  // index 0 is x space, index 1 is y space
  generate
    for (genvar g = 0; g < 2; g++) begin : g_dmem
      logic [23:0] dram [onchip_mem_pkg::DRAM_DEPTH];
      onchip_mem_pkg::mem_req_t rq;
      logic [12:0] lim;
      logic [15:0] rom_end;

      // this space's request, ram limit, rom end
      assign rq = (g == 0) ? i_x_req : i_y_req;
      assign lim = (g == 0) ? xram_w : yram_w;
      assign rom_end = (g == 0) ? onchip_mem_pkg::XROM_END :
                                  onchip_mem_pkg::YROM_END;

      // gap between ram and rom base reads undefined, not illegal
      // software must not rely on that fill
      always_comb begin
        if (rq.addr < {3'h0, lim}) begin
          d_kind[g] = K_RAM;
        end else if (rq.addr < onchip_mem_pkg::DROM_BASE) begin
          d_kind[g] = K_UNDEF;
        end else if (rq.addr < rom_end) begin
          d_kind[g] = K_ROM;
        end else begin
          d_kind[g] = K_ILL;
        end
      end

      // only ram takes writes; rom and reserved drop them
      // the undefined gap drops writes too
      always_ff @(posedge i_mclk) begin
        if (rq.req && rq.we && d_kind[g] == K_RAM) begin
          dram[rq.addr[12:0]] <= rq.wdata;
        end
      end

      // reserved reads answer the illegal opcode
      always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          d_rdata[g] <= 24'h000000;
        end else if (rq.req && !rq.we) begin
          case (d_kind[g])
            K_RAM: d_rdata[g] <= dram[rq.addr[12:0]];
            K_ROM: d_rdata[g] <= onchip_mem_pkg::ROM_FILL;
            K_UNDEF: d_rdata[g] <= onchip_mem_pkg::UNDEF_FILL;
            default: d_rdata[g] <= onchip_mem_pkg::ILLEGAL_OP;
          endcase
        end
      end
    end
  endgenerate

  // per-space read data onto the ports
  assign o_x_rdata = d_rdata[0];
  assign o_y_rdata = d_rdata[1];

  // apb answers with no wait state; data is caught in setup
  // trade: prdata is a flop, one cycle old
  assign o_pready = 1'b1;
  // a write lands in the access phase only
  assign apb_wr = i_psel && i_penable && i_pwrite;

  // next state: config, reserved-read counter, vector, apb
  // fields start from their registered value
  // so events in one cycle never clear others
  always_comb begin
    logic ill_p;
    logic ill_x;
    logic ill_y;
    logic [15:0] va;
    logic [2:0] cnt_inc;
    ill_p = 1'b0;
    ill_x = 1'b0;
    ill_y = 1'b0;
    va = 16'h0000;
    cnt_inc = 3'h0;
    st_nxt = st_r;

    // reserved reads and fetches raise the illegal interrupt
    // one shared pulse; counter adds every hit
    ill_p = i_p_req.req && !i_p_req.we && p_kind == K_ILL;
    ill_x = i_x_req.req && !i_x_req.we && d_kind[0] == K_ILL;
    ill_y = i_y_req.req && !i_y_req.we && d_kind[1] == K_ILL;
    st_nxt.ill_irq = ill_p || ill_x || ill_y;
    cnt_inc = {2'h0, ill_p} + {2'h0, ill_x} + {2'h0, ill_y};
    st_nxt.ill_cnt = st_r.ill_cnt + {13'h0000, cnt_inc};

    // vector lookup, slots are two words apart
    // only audio sources relocate; a bad host
    // slot cannot land on another vector
    st_nxt.vec.valid = i_vec_req.req;
    if (i_vec_req.req) begin
      va = onchip_mem_pkg::vec_base(i_vec_req.src);
      case (i_vec_req.src)
        onchip_mem_pkg::VS_SAP_TXL, onchip_mem_pkg::VS_SAP_TXR,
        onchip_mem_pkg::VS_SAP_TXE: begin
          if (st_r.cfg[onchip_mem_pkg::CFG_TX_REL]) begin
            va = va + onchip_mem_pkg::SAP_RELOC_OFS;
          end
        end
        onchip_mem_pkg::VS_SAP_RXL, onchip_mem_pkg::VS_SAP_RXR,
        onchip_mem_pkg::VS_SAP_RXE: begin
          if (st_r.cfg[onchip_mem_pkg::CFG_RX_REL]) begin
            va = va + onchip_mem_pkg::SAP_RELOC_OFS;
          end
        end
        onchip_mem_pkg::VS_PHP_CMD: begin
          // free slots only; anything else falls back to default
          case (i_vec_req.hc_slot)
            6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h1E, 6'h26, 6'h27, 6'h2A:
              va = {9'h000, i_vec_req.hc_slot, 1'b0};
            default: begin
              if (i_vec_req.hc_slot >= 6'h2C) begin
                va = {9'h000, i_vec_req.hc_slot, 1'b0};
              end else begin
                va = {9'h000, onchip_mem_pkg::HC_DEFAULT_SLOT, 1'b0};
              end
            end
          endcase
        end
        default: va = va;
      endcase
      st_nxt.vec.addr = va;
      // level 3: reset to illegal in enum order
      st_nxt.vec.fixed_l3 = (i_vec_req.src <= onchip_mem_pkg::VS_ILLEGAL);
    end

    // apb setup phase: capture read data and error answer
    // unmapped or read-only writes: error
    if (i_psel && !i_penable) begin
      st_nxt.slverr = 1'b0;
      st_nxt.prdata = 32'h00000000;
      case (i_paddr)
        onchip_mem_pkg::OFS_CFG:
          st_nxt.prdata = {24'h000000, st_r.cfg};
        onchip_mem_pkg::OFS_STAT:
          st_nxt.slverr = i_pwrite;
        onchip_mem_pkg::OFS_SIZE:
          st_nxt.slverr = i_pwrite;
        default: st_nxt.slverr = 1'b1;
      endcase
      if (i_paddr == onchip_mem_pkg::OFS_STAT) begin
        st_nxt.prdata = {16'h0000, st_r.ill_cnt};
      end
      if (i_paddr == onchip_mem_pkg::OFS_SIZE) begin
        st_nxt.prdata = {6'h00, yram_w, xram_w[12:0] == 13'h0000,
                         pram_w[11:0]};
      end
    end

    // apb access phase: only the config word is writable
    // error writes change nothing
    if (apb_wr && i_paddr == onchip_mem_pkg::OFS_CFG) begin
      st_nxt.cfg = i_pwdata[7:0];
    end
  end

  // one register stage for all control state
  // reset: boot active, all else cleared
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= state_t'({onchip_mem_pkg::CFG_RESET,
                        ($bits(state_t) - 8)'(0)});
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs come straight from the state flops
  // boot select bits steer the loader that sits outside this block
  assign o_boot_sel = st_r.cfg[onchip_mem_pkg::CFG_BOOT_LO +: 3];
  assign o_boot_active = st_r.cfg[onchip_mem_pkg::CFG_BOOT_ACT];
  assign o_illegal_irq = st_r.ill_irq;
  assign o_vec = st_r.vec;
  assign o_prdata = st_r.prdata;
  assign o_pslverr = st_r.slverr;

endmodule : onchip_mem_map

`default_nettype wire

// ===== include/onchip_mem_pkg.sv
// package for the on-chip memory map and vector decoder
// assumes one core clock; all maps are in 24-bit word addresses
package onchip_mem_pkg;

  // program, x and y word width
  localparam int unsigned WORD_W = 24;
  localparam logic [23:0] ILLEGAL_OP = 24'h000005;
  localparam logic [23:0] UNDEF_FILL = 24'h000000;
  localparam logic [23:0] ROM_FILL = 24'h000000;
  localparam logic [23:0] BLOCK_FILL = 24'h000000;

  // program space layout
  localparam logic [15:0] BOOT_ROM_END = 16'h001F;
  localparam logic [15:0] BOOT_PROT_END = 16'h00FF;
  localparam logic [15:0] PROM_BASE = 16'h1000;
  localparam logic [15:0] PROM_LAST = 16'h4BFF;
  localparam int unsigned PRAM_DEPTH = 2560;

  // program, x and y ram words per split setting none, a, b, a+b
  localparam logic [12:0] PRAM_W0 = 13'h0100;
  localparam logic [12:0] PRAM_W1 = 13'h0400;
  localparam logic [12:0] PRAM_W2 = 13'h0700;
  localparam logic [12:0] PRAM_W3 = 13'h0A00;
  localparam logic [12:0] XRAM_W0 = 13'h1000;
  localparam logic [12:0] XRAM_W1 = 13'h0D00;
  localparam logic [12:0] XRAM_W3 = 13'h0A00;
  localparam logic [12:0] YRAM_W0 = 13'h1100;
  localparam logic [12:0] YRAM_W2 = 13'h0E00;
  localparam int unsigned DRAM_DEPTH = 4352;

  // data rom windows; at and above the end is illegal space
  localparam logic [15:0] DROM_BASE = 16'h2000;
  localparam logic [15:0] XROM_END = 16'h2E00;
  localparam logic [15:0] YROM_END = 16'h2800;

  // apb register map
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_SIZE = 8'h08;
  localparam int unsigned CFG_SPLIT_A = 0;
  localparam int unsigned CFG_SPLIT_B = 1;
  localparam int unsigned CFG_TX_REL = 2;
  localparam int unsigned CFG_RX_REL = 3;
  localparam int unsigned CFG_BOOT_LO = 4;
  localparam int unsigned CFG_BOOT_ACT = 7;
  localparam logic [7:0] CFG_RESET = 8'h80;

  // vector map
  localparam logic [15:0] SAP_RELOC_OFS = 16'h0030;
  localparam logic [5:0] HC_DEFAULT_SLOT = 6'h1A;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [23:0] wdata;
  } mem_req_t;

  typedef enum logic [4:0] {
    VS_RESET, VS_STACK_ERR, VS_TRACE, VS_SOFT_INT, VS_NMI, VS_ILLEGAL,
    VS_SAP_TXL, VS_SAP_TXR, VS_SAP_TXE, VS_SAP_RXL, VS_SAP_RXR,
    VS_SAP_RXE, VS_SHP_TX, VS_SHP_TXU, VS_SHP_RNE, VS_SHP_RFF,
    VS_SHP_ROV, VS_SHP_BERR, VS_PHP_RX, VS_PHP_TX, VS_PHP_CMD,
    VS_ATX_UND, VS_ATX_BLK, VS_ATX_TRE
  } vec_src_t;

  typedef struct packed {
    logic req;
    vec_src_t src;
    logic [5:0] hc_slot;
  } vec_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic fixed_l3;
  } vec_out_t;

  // starting slot of each source before any relocation
  function automatic logic [15:0] vec_base(input vec_src_t s);
    case (s)
      VS_RESET: vec_base = 16'h0000;
      VS_STACK_ERR: vec_base = 16'h0002;
      VS_TRACE: vec_base = 16'h0004;
      VS_SOFT_INT: vec_base = 16'h0006;
      VS_SAP_TXL: vec_base = 16'h0010;
      VS_SAP_TXR: vec_base = 16'h0012;
      VS_SAP_TXE: vec_base = 16'h0014;
      VS_SAP_RXL: vec_base = 16'h0016;
      VS_SAP_RXR: vec_base = 16'h0018;
      VS_SAP_RXE: vec_base = 16'h001A;
      VS_NMI: vec_base = 16'h001E;
      VS_SHP_TX: vec_base = 16'h0020;
      VS_SHP_TXU: vec_base = 16'h0022;
      VS_SHP_RNE: vec_base = 16'h0024;
      VS_SHP_RFF: vec_base = 16'h0028;
      VS_SHP_ROV: vec_base = 16'h002A;
      VS_SHP_BERR: vec_base = 16'h002C;
      VS_PHP_RX: vec_base = 16'h0030;
      VS_PHP_TX: vec_base = 16'h0032;
      VS_ILLEGAL: vec_base = 16'h003E;
      VS_ATX_UND: vec_base = 16'h0050;
      VS_ATX_BLK: vec_base = 16'h0052;
      VS_ATX_TRE: vec_base = 16'h0056;
      default: vec_base = 16'h0034;
    endcase
  endfunction : vec_base

endpackage : onchip_mem_pkg

// ===== verification/core_bus_model.sv
// core-side model of the program, x and y buses and the vector requests
// assumes each task is entered just after a rising edge of i_clk
`timescale 1ns/1ps
`default_nettype none
module core_bus_model (
  input wire logic i_clk,
  input wire logic [23:0] i_p_rdata,
  input wire logic [23:0] i_x_rdata,
  input wire logic [23:0] i_y_rdata,
  input wire logic i_irq,
  input wire onchip_mem_pkg::vec_out_t i_vec,
  output wire onchip_mem_pkg::mem_req_t o_p_req,
  output wire onchip_mem_pkg::mem_req_t o_x_req,
  output wire onchip_mem_pkg::mem_req_t o_y_req,
  output wire onchip_mem_pkg::vec_req_t o_vec_req
);
  onchip_mem_pkg::mem_req_t req [3] = '{default: '0};
  onchip_mem_pkg::vec_req_t vreq = '0;
  // space 0 program, 1 x, 2 y
  assign o_p_req = req[0];
  assign o_x_req = req[1];
  assign o_y_req = req[2];
  assign o_vec_req = vreq;

  // one request held over its taking edge; answer looked at mid-cycle
  task automatic mem_op(input int sp, input logic we,
    input logic [15:0] a, input logic [23:0] d,
    output logic [23:0] q, output logic irq);
    req[sp] <= '{1'b1, we, a, d};
    @(posedge i_clk);
    req[sp] <= '{1'b0, ~we, ~a, ~d};
    @(negedge i_clk);
    q = (sp == 0) ? i_p_rdata : (sp == 1) ? i_x_rdata : i_y_rdata;
    irq = i_irq;
    @(posedge i_clk);
  endtask : mem_op

  // released slot lines are inverted so no stale value lingers
  task automatic vec_op(input onchip_mem_pkg::vec_src_t s,
    input logic [5:0] slot, output onchip_mem_pkg::vec_out_t v);
    vreq <= '{1'b1, s, slot};
    @(posedge i_clk);
    vreq <= '{1'b0, s, ~slot};
    @(negedge i_clk);
    v = i_vec;
    @(posedge i_clk);
  endtask : vec_op
endmodule : core_bus_model
`default_nettype wire

// ===== verification/onchip_mem_map_props.sv
// port assertions for the memory map: reserved answers, boot window,
// vector lookup; bound into every onchip_mem_map instance
`timescale 1ns/1ps
`default_nettype none
module onchip_mem_map_chk #(
  parameter logic [23:0] BOOT_ROM_WORD = 24'h000000
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire onchip_mem_pkg::mem_req_t i_p_req,
  input wire onchip_mem_pkg::mem_req_t i_x_req,
  input wire onchip_mem_pkg::mem_req_t i_y_req,
  input wire logic [23:0] o_p_rdata,
  input wire logic [23:0] o_x_rdata,
  input wire logic [23:0] o_y_rdata,
  input wire logic o_illegal_irq,
  input wire onchip_mem_pkg::vec_req_t i_vec_req,
  input wire onchip_mem_pkg::vec_out_t o_vec,
  input wire logic o_boot_active
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  // read strobes; writes never produce an answer
  wire logic p_rd = i_p_req.req && !i_p_req.we;
  wire logic x_rd = i_x_req.req && !i_x_req.we;
  wire logic y_rd = i_y_req.req && !i_y_req.we;
  wire logic [15:0] pa = i_p_req.addr;

  property p_x_ill;
    x_rd && i_x_req.addr >= 16'h2E00 |=>
      o_x_rdata == onchip_mem_pkg::ILLEGAL_OP && o_illegal_irq;
  endproperty
  a_x_ill: assert property (p_x_ill)
    else $error("x reserved read answer wrong");
  property p_y_ill;
    y_rd && i_y_req.addr >= 16'h2800 |=>
      o_y_rdata == onchip_mem_pkg::ILLEGAL_OP && o_illegal_irq;
  endproperty
  a_y_ill: assert property (p_y_ill)
    else $error("y reserved read answer wrong");
  property p_p_ill;
    p_rd && pa >= 16'h4C00 |=>
      o_p_rdata == onchip_mem_pkg::ILLEGAL_OP && o_illegal_irq;
  endproperty
  a_p_ill: assert property (p_p_ill)
    else $error("program reserved fetch answer wrong");
  property p_boot_rom;
    o_boot_active && p_rd && pa <= 16'h001F |=> o_p_rdata == BOOT_ROM_WORD;
  endproperty
  a_boot_rom: assert property (p_boot_rom)
    else $error("boot rom word wrong");
  property p_boot_blk;
    o_boot_active && p_rd && pa inside {[16'h0020:16'h00FF]} |=>
      o_p_rdata == onchip_mem_pkg::BLOCK_FILL && !o_illegal_irq;
  endproperty
  a_boot_blk: assert property (p_boot_blk)
    else $error("boot blocked read leaked");
  // an illegal pulse needs a read one cycle before
  property p_irq_cause;
    !(p_rd || x_rd || y_rd) |=> !o_illegal_irq;
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("illegal pulse without read");
  property p_vec_slot;
    i_vec_req.req |-> ##1 o_vec.valid && o_vec.addr < 16'h0080 &&
      !o_vec.addr[0];
  endproperty
  a_vec_slot: assert property (p_vec_slot)
    else $error("vector outside slot area");
  property p_vec_lvl;
    i_vec_req.req |=> o_vec.fixed_l3 ==
      ($past(i_vec_req.src) <= onchip_mem_pkg::VS_ILLEGAL);
  endproperty
  a_vec_lvl: assert property (p_vec_lvl)
    else $error("vector level class wrong");
  property p_x_hold;
    !x_rd |=> $stable(o_x_rdata);
  endproperty
  a_x_hold: assert property (p_x_hold)
    else $error("x read data moved without read");

  c_ill: cover property (o_illegal_irq);
  c_vec: cover property (o_vec.valid && !o_vec.fixed_l3);
  c_boot: cover property (o_boot_active && p_rd);
endmodule : onchip_mem_map_chk

bind onchip_mem_map onchip_mem_map_chk #(.BOOT_ROM_WORD(BOOT_ROM_WORD)) u_chk (
  .i_mclk(i_mclk),
  .i_arst_n(i_arst_n),
  .i_p_req(i_p_req),
  .i_x_req(i_x_req),
  .i_y_req(i_y_req),
  .o_p_rdata(o_p_rdata),
  .o_x_rdata(o_x_rdata),
  .o_y_rdata(o_y_rdata),
  .o_illegal_irq(o_illegal_irq),
  .i_vec_req(i_vec_req),
  .o_vec(o_vec),
  .o_boot_active(o_boot_active)
);
`default_nettype wire

// ===== verification/test_onchip_mem_map.sv
// self-checking bench for the memory map: apb config, all three spaces,
// boot window, reserved answers and the vector lookup
`timescale 1ns/1ps
`default_nettype none
module test_onchip_mem_map;
  localparam logic [23:0] BOOT_WORD = 24'h5A5A5A;
  logic mclk;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  onchip_mem_pkg::mem_req_t p_req, x_req, y_req;
  logic [23:0] p_rd, x_rd, y_rd;
  logic irq;
  onchip_mem_pkg::vec_req_t vec_req;
  onchip_mem_pkg::vec_out_t vec, v;
  logic [2:0] boot_sel;
  logic boot_act;
  logic [31:0] q, cnt;
  logic e, ir;
  logic [23:0] m;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  // space sizes per split setting; program, x, y
  logic [15:0] sz [3][4] = '{'{16'h0100, 16'h0400, 16'h0700, 16'h0A00},
    '{16'h1000, 16'h0D00, 16'h0D00, 16'h0A00},
    '{16'h1100, 16'h1100, 16'h0E00, 16'h0E00}};
  logic [15:0] ill [3] = '{16'h4C00, 16'h2E00, 16'h2800};
  logic [15:0] rom [3] = '{16'h4BFF, 16'h2DFF, 16'h27FF};
  logic [7:0] vx [24] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h1E, 8'h3E, 8'h10,
    8'h12, 8'h14, 8'h16, 8'h18, 8'h1A, 8'h20, 8'h22, 8'h24, 8'h28, 8'h2A,
    8'h2C, 8'h30, 8'h32, 8'h34, 8'h50, 8'h52, 8'h56};
  logic [5:0] hs [4] = '{6'h1B, 6'h27, 6'h3F, 6'h10};
  logic [7:0] hx [4] = '{8'h36, 8'h4E, 8'h7E, 8'h34};

  onchip_mem_map #(.BOOT_ROM_WORD(BOOT_WORD)) uut (.i_mclk(mclk),
    .i_arst_n(arst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .i_p_req(p_req), .i_x_req(x_req), .i_y_req(y_req),
    .o_p_rdata(p_rd), .o_x_rdata(x_rd), .o_y_rdata(y_rd),
    .o_illegal_irq(irq), .i_vec_req(vec_req), .o_vec(vec),
    .o_boot_sel(boot_sel), .o_boot_active(boot_act));
  core_bus_model core (.i_clk(mclk), .i_p_rdata(p_rd), .i_x_rdata(x_rd),
    .i_y_rdata(y_rd), .i_irq(irq), .i_vec(vec), .o_p_req(p_req),
    .o_x_req(x_req), .o_y_req(y_req), .o_vec_req(vec_req));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      close_out();
    end
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rq, output logic er);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rq = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  initial begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    apb(0, onchip_mem_pkg::OFS_CFG, 0, q, e);
    check(q, 32'h80);
    apb(1, onchip_mem_pkg::OFS_CFG, 32'hD0, q, e);
    check({boot_act, boot_sel}, 4'hD);
    core.mem_op(0, 1, 16'h0020, 24'h123456, m, ir);
    core.mem_op(0, 0, 16'h0020, 0, m, ir);
    check(m, onchip_mem_pkg::BLOCK_FILL);
    core.mem_op(0, 0, 16'h001F, 0, m, ir);
    check(m, BOOT_WORD);
    // leaving boot must expose what was written meanwhile
    apb(1, onchip_mem_pkg::OFS_CFG, 32'h50, q, e);
    core.mem_op(0, 0, 16'h0020, 0, m, ir);
    check(m, 24'h123456);
    for (int s = 0; s < 4; s++) begin
      apb(1, onchip_mem_pkg::OFS_CFG, 32'(s), q, e);
      apb(0, onchip_mem_pkg::OFS_SIZE, 0, q, e);
      check(q[11:0], sz[0][s]);
      for (int sp = 0; sp < 3; sp++) begin
        core.mem_op(sp, 1, sz[sp][s] - 16'h1, 24'hC0DE00 | 24'(s), m, ir);
        core.mem_op(sp, 0, sz[sp][s] - 16'h1, 0, m, ir);
        check(m, 24'hC0DE00 | 24'(s));
      end
      core.mem_op(0, 0, sz[0][s], 0, m, ir);
      check({ir, m}, {1'b1, onchip_mem_pkg::ILLEGAL_OP});
    end
    apb(0, onchip_mem_pkg::OFS_STAT, 0, q, e);
    cnt = q;
    for (int i = 0; i < 3; i++) begin
      core.mem_op(i, 1, ill[i], 24'h777777, m, ir);
      core.mem_op(i, 0, ill[i], 0, m, ir);
      check({ir, m}, {1'b1, onchip_mem_pkg::ILLEGAL_OP});
      core.mem_op(i, 1, rom[i], 24'h777777, m, ir);
      core.mem_op(i, 0, rom[i], 0, m, ir);
      check({ir, m}, {1'b0, onchip_mem_pkg::ROM_FILL});
    end
    core.mem_op(1, 0, 16'h1FFF, 0, m, ir);
    check(ir, 1'b0);
    apb(0, onchip_mem_pkg::OFS_STAT, 0, q, e);
    check(q[15:0], cnt[15:0] + 16'h3);
    apb(1, onchip_mem_pkg::OFS_STAT, 32'hFFFF, q, e);
    check(e, 1'b1);
    apb(0, 8'h0C, 0, q, e);
    check({e, q}, {1'b1, 32'h0});
    apb(1, onchip_mem_pkg::OFS_CFG, 0, q, e);
    for (int i = 0; i < 24; i++) begin
      core.vec_op(onchip_mem_pkg::vec_src_t'(i), 6'h00, v);
      check({v.valid, v.fixed_l3, v.addr}, {1'b1, 1'(i < 6), 8'h0, vx[i]});
    end
    // transmit relocation alone, then receive alone
    for (int c = 1; c < 3; c++) begin
      apb(1, onchip_mem_pkg::OFS_CFG, 32'(c * 4), q, e);
      for (int i = 6; i < 12; i++) begin
        core.vec_op(onchip_mem_pkg::vec_src_t'(i), 6'h00, v);
        check(v.addr, vx[i] + (((i < 9) == (c == 1)) ? 16'h30 : 16'h0));
      end
    end
    for (int i = 0; i < 4; i++) begin
      core.vec_op(onchip_mem_pkg::VS_PHP_CMD, hs[i], v);
      check(v.addr, hx[i]);
    end
    close_out();
  end
endmodule : test_onchip_mem_map
`default_nettype wire
